// ---- rtl/bafrm_framer.v ----
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "bafrm_consts.vh"

module bafrm_framer (
  input wire clk_sys_i,
  input wire reset_n_i,
  // Register port
  input wire [15:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output reg irq_o,
  // Board state
  input wire [4:0] geo_addr_i,
  input wire geo_auto_i,
  input wire [31:0] fault_status_i,
  input wire [15:0] io_pattern_i,
  // Channel aggregate sources, word streams
  input wire [7:0] ch_ready_i,
  input wire [255:0] ch_data_i,
  input wire [7:0] ch_valid_i,
  input wire [7:0] ch_last_i,
  input wire [223:0] ch_len_i,
  output reg [7:0] ch_pop_o,
  // Host block transfer side
  input wire blk_start_i,
  input wire out_ready_i,
  output reg [31:0] out_data_o,
  output reg out_valid_o,
  output reg out_rec_end_o,
  output reg blk_done_o,
  output reg rd_req_o
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_HDR = 4'b0010;
  localparam ST_CH = 4'b0100;
  localparam ST_NEXT = 4'b1000;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [4:0] bid_r;
  reg bid_sw_r;
  reg [7:0] ch_en_r;
  reg [7:0] maxrec_r;
  reg [2:0] irq_st_r;
  reg [2:0] irq_msk_r;
  reg [31:0] rec_cnt_r;
  reg [31:0] time_r;
  reg fail_d_r;

  wire fail_now = |fault_status_i;
  wire [4:0] bid_eff = bid_sw_r ? bid_r :
    (geo_auto_i ? geo_addr_i : `BAFRM_BID_RST);
  wire [7:0] take = ch_ready_i & ch_en_r;

  function [27:0] rec_len;
    input [7:0] m;
    input [223:0] lens;
    integer k;
    begin
      rec_len = `BAFRM_HDR_WORDS;
      for (k = 0; k < `BAFRM_NCH; k = k + 1) begin
        if (m[k])
          rec_len = rec_len + lens[k*28 +: 28];
      end
    end
  endfunction

  function [2:0] first_ch;
    input [7:0] m;
    integer k;
    begin
      first_ch = 3'h0;
      for (k = `BAFRM_NCH - 1; k >= 0; k = k - 1) begin
        if (m[k])
          first_ch = k[2:0];
      end
    end
  endfunction

  // Same compare serves every write decode
  function reg_hit;
    input [15:0] a;
    input [15:0] r;
    begin
      reg_hit = (a == r);
    end
  endfunction

  function [7:0] ch_bit;
    input [2:0] c;
    begin
      ch_bit = 8'h01 << c;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Channel word lanes, one per source
  wire [31:0] lane_word [0:7];
  genvar g;
  generate
    for (g = 0; g < `BAFRM_NCH; g = g + 1) begin : g_lane
      assign lane_word[g] = ch_data_i[g*32 +: 32];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Framer state
  reg [3:0] st_r;
  reg [1:0] hw_r;
  reg [7:0] mask_r;
  reg [7:0] left_r;
  reg [2:0] ch_r;
  reg [27:0] len_r;
  reg [15:0] pat_r;
  reg [31:0] tstamp_r;
  reg [31:0] cnt_snap_r;
  reg fail_snap_r;
  reg [4:0] bid_snap_r;
  reg [7:0] recs_r;
  reg in_blk_r;

  wire out_fire = out_valid_o & out_ready_i;
  wire [31:0] ch_word = lane_word[ch_r];
  wire ch_v = ch_valid_i[ch_r];
  wire ch_l = ch_last_i[ch_r];
  wire [7:0] left_nxt = left_r & ~ch_bit(ch_r);
  // A popped source needs one cycle before its ready and data move on
  wire pop_wait = (ch_pop_o != 8'h00);
  wire next_go = (st_r == ST_NEXT) && (!out_valid_o || out_fire)
    && !pop_wait;
  // Cap counts the record now closing
  wire more_ok = (recs_r + 8'h01 < maxrec_r) && (|take);

  // Header words are built from the snapshot taken at record capture
  reg [31:0] hdr_word;
  always @* begin
    hdr_word = 32'h00000000;
    case (hw_r)
      2'h0: hdr_word = {`BAFRM_TAG, len_r};
      2'h1: hdr_word = {8'h00, bid_snap_r, fail_snap_r, pat_r[9:0],
        mask_r};
      2'h2: hdr_word = cnt_snap_r;
      2'h3: hdr_word = tstamp_r;
      default: hdr_word = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st_r <= ST_IDLE;
      hw_r <= 2'h0;
      mask_r <= 8'h00;
      left_r <= 8'h00;
      ch_r <= 3'h0;
      len_r <= 28'h0;
      pat_r <= 16'h0000;
      tstamp_r <= 32'h00000000;
      cnt_snap_r <= 32'h00000000;
      fail_snap_r <= 1'b0;
      bid_snap_r <= 5'h00;
      recs_r <= 8'h00;
      in_blk_r <= 1'b0;
      rec_cnt_r <= 32'h00000000;
      out_data_o <= 32'h00000000;
      out_valid_o <= 1'b0;
      out_rec_end_o <= 1'b0;
      blk_done_o <= 1'b0;
      ch_pop_o <= 8'h00;
    end else begin
      blk_done_o <= 1'b0;
      ch_pop_o <= 8'h00;
      if (out_fire) begin
        out_valid_o <= 1'b0;
        out_rec_end_o <= 1'b0;
      end
      case (st_r)
        ST_IDLE: begin
          if (blk_start_i)
            in_blk_r <= 1'b1;
          // Snapshot everything the header needs in one cycle
          if ((blk_start_i || in_blk_r) && (|take) && !out_valid_o
              && maxrec_r != 8'h00) begin
            st_r <= ST_HDR;
            hw_r <= 2'h0;
            mask_r <= take;
            left_r <= take;
            ch_r <= first_ch(take);
            len_r <= rec_len(take, ch_len_i);
            pat_r <= io_pattern_i;
            tstamp_r <= time_r;
            cnt_snap_r <= rec_cnt_r;
            fail_snap_r <= fail_now;
            bid_snap_r <= bid_eff;
          end
        end
        ST_HDR: begin
          if (!out_valid_o || out_fire) begin
            out_valid_o <= 1'b1;
            hw_r <= hw_r + 2'h1;
            out_data_o <= hdr_word;
            if (hw_r == 2'h3)
              st_r <= ST_CH;
          end
        end
        ST_CH: begin
          // Only the current channel drains: one aggregate, ascending
          if ((!out_valid_o || out_fire) && ch_v && !pop_wait) begin
            out_valid_o <= 1'b1;
            out_data_o <= ch_word;
            ch_pop_o <= ch_bit(ch_r);
            if (ch_l) begin
              left_r <= left_nxt;
              ch_r <= first_ch(left_nxt);
              if (left_nxt == 8'h00) begin
                out_rec_end_o <= 1'b1;
                st_r <= ST_NEXT;
              end
            end
          end
        end
        ST_NEXT: begin
          if (next_go) begin
            rec_cnt_r <= rec_cnt_r + 32'h00000001;
            recs_r <= recs_r + 8'h01;
            if (more_ok) begin
              // Start next record at once, no gap
              st_r <= ST_HDR;
              hw_r <= 2'h0;
              mask_r <= take;
              left_r <= take;
              ch_r <= first_ch(take);
              len_r <= rec_len(take, ch_len_i);
              pat_r <= io_pattern_i;
              tstamp_r <= time_r;
              cnt_snap_r <= rec_cnt_r + 32'h00000001;
              fail_snap_r <= fail_now;
              bid_snap_r <= bid_eff;
            end else begin
              st_r <= ST_IDLE;
              in_blk_r <= 1'b0;
              recs_r <= 8'h00;
              blk_done_o <= 1'b1;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Free-running creation time, wraps silently
  always @(posedge clk_sys_i) begin
    if (!reset_n_i)
      time_r <= 32'h00000000;
    else
      time_r <= time_r + 32'h00000001;
  end

  // Level request, registered so the host sees no glitch
  always @(posedge clk_sys_i) begin
    if (!reset_n_i)
      rd_req_o <= 1'b0;
    else
      rd_req_o <= |ch_ready_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt
  // Record events fire once per record hand-over, not per waiting cycle; fault fires on its rising edge
  wire [2:0] irq_ev = {next_go && !more_ok, fail_now && !fail_d_r,
    next_go};
  // Unmapped and read-only writes fall through
  wire wr_bid = reg_wr_i && reg_hit(reg_addr_i, `BAFRM_ADDR_BID);
  wire wr_ctrl = reg_wr_i && reg_hit(reg_addr_i, `BAFRM_ADDR_CTRL);
  wire wr_maxrec = reg_wr_i && reg_hit(reg_addr_i, `BAFRM_ADDR_MAXREC);
  wire wr_irqst = reg_wr_i && reg_hit(reg_addr_i, `BAFRM_ADDR_IRQST);
  wire wr_irqmsk = reg_wr_i && reg_hit(reg_addr_i, `BAFRM_ADDR_IRQMSK);
  wire [2:0] irq_clr = wr_irqst ? reg_wdata_i[2:0] : 3'h0;
  reg [31:0] rd_mux;

  // Identity written by software wins over the slot address until reset
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      bid_r <= `BAFRM_BID_RST;
      bid_sw_r <= 1'b0;
    end else if (wr_bid) begin
      bid_r <= reg_wdata_i[4:0];
      bid_sw_r <= 1'b1;
    end
  end

  // Channel enables, record cap and interrupt mask
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ch_en_r <= `BAFRM_CTRL_RST;
      maxrec_r <= `BAFRM_MAXREC_RST;
      irq_msk_r <= 3'h0;
    end else begin
      if (wr_ctrl)
        ch_en_r <= reg_wdata_i[7:0];
      if (wr_maxrec)
        maxrec_r <= reg_wdata_i[7:0];
      if (wr_irqmsk)
        irq_msk_r <= reg_wdata_i[2:0];
    end
  end

  // Set wins over write-one clear, so no event is lost to a racing clear
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      irq_st_r <= 3'h0;
      fail_d_r <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      fail_d_r <= fail_now;
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
      irq_o <= |(irq_st_r & irq_msk_r);
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (reg_addr_i)
      `BAFRM_ADDR_FAIL: rd_mux = fault_status_i;
      `BAFRM_ADDR_BID: rd_mux = {27'h0, bid_eff};
      `BAFRM_ADDR_CTRL: rd_mux = {24'h0, ch_en_r};
      `BAFRM_ADDR_MAXREC: rd_mux = {24'h0, maxrec_r};
      `BAFRM_ADDR_IRQST: rd_mux = {29'h0, irq_st_r};
      `BAFRM_ADDR_IRQMSK: rd_mux = {29'h0, irq_msk_r};
      `BAFRM_ADDR_CNT: rd_mux = rec_cnt_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data stands in each cycle after one with reg_rd_i high, zero otherwise
  always @(posedge clk_sys_i) begin
    if (!reset_n_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_rd_i)
      reg_rdata_o <= rd_mux;
    else
      reg_rdata_o <= 32'h00000000;
  end

endmodule // bafrm_framer
`default_nettype wire

// ---- shared/bafrm_consts.vh ----
`ifndef BAFRM_CONSTS_VH
`define BAFRM_CONSTS_VH

`define BAFRM_NCH 8
`define BAFRM_TAG 4'hA
`define BAFRM_HDR_WORDS 28'h0000004
`define BAFRM_ADDR_FAIL 16'h8178
`define BAFRM_ADDR_BID 16'hEF08
`define BAFRM_ADDR_CTRL 16'hEF10
`define BAFRM_ADDR_MAXREC 16'hEF14
`define BAFRM_ADDR_IRQST 16'hEF18
`define BAFRM_ADDR_IRQMSK 16'hEF1C
`define BAFRM_ADDR_CNT 16'hEF20
`define BAFRM_BID_RST 5'h00
`define BAFRM_MAXREC_RST 8'h01
`define BAFRM_CTRL_RST 8'hFF
`define BAFRM_IRQ_REC 0
`define BAFRM_IRQ_FAIL 1
`define BAFRM_IRQ_BLK 2

`endif

// ---- testbench/bafrm_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module bafrm_chk (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [7:0] ch_ready_i,
  input wire logic [7:0] ch_pop_o,
  input wire logic out_ready_i,
  input wire logic [31:0] out_data_o,
  input wire logic out_valid_o,
  input wire logic out_rec_end_o,
  input wire logic blk_done_o,
  input wire logic rd_req_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic head_r;
  // Next word shown opens a record
  always_ff @(posedge clk_sys_i)
    if (!reset_n_i) head_r <= 1'b1;
    else if (out_valid_o && out_ready_i) head_r <= out_rec_end_o;
  a_req_or: assert property (
    $past(reset_n_i) |-> rd_req_o == ($past(ch_ready_i) != 8'h00))
    else $error("read request wrong");
  a_rdata_zero: assert property (
    $past(reset_n_i) && !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside slot");
  a_word_holds: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("word lost while stalled");
  a_pop_single: assert property ($onehot0(ch_pop_o))
    else $error("two channels popped");
  a_pop_shown: assert property (ch_pop_o != 8'h00 |-> out_valid_o)
    else $error("pop without word");
  a_end_shown: assert property (out_rec_end_o |-> out_valid_o)
    else $error("record end without word");
  a_tag_head: assert property (
    head_r && out_valid_o |-> out_data_o[31:28] == 4'hA && ch_pop_o == 8'h00)
    else $error("record not opened by header");
  a_done_pulse: assert property (blk_done_o |=> !blk_done_o)
    else $error("block done not a pulse");
  c_rec: cover property (out_valid_o && out_ready_i && out_rec_end_o);
  c_stall: cover property (out_valid_o && !out_ready_i);
  c_done: cover property (blk_done_o);
endmodule // bafrm_chk
`default_nettype wire

// ---- testbench/bafrm_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module bafrm_host (
  input wire logic clk_sys_i,
  input wire logic stall_i,
  input wire logic [31:0] data_i,
  input wire logic valid_i,
  output logic ready_o
);
  logic [31:0] words[$];
  logic tog_r = 1'b0;
  initial ready_o = 1'b0;
  // Stalling takes every other beat, so held words get exercised
  always @(posedge clk_sys_i) begin
    tog_r <= ~tog_r;
    ready_o <= !stall_i || tog_r;
    if (valid_i && ready_o) words.push_back(data_i);
  end
endmodule // bafrm_host
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bafrm_consts.vh"
module tb_top;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000, io_pattern_i = 16'h02A5;
  logic [31:0] reg_wdata_i = 32'h0, fault_status_i = 32'h0;
  logic [31:0] reg_rdata_o, out_data_o, prev_cnt, prev_time;
  logic [4:0] geo_addr_i = 5'h0B;
  logic geo_auto_i = 1'b1, blk_start_i = 1'b0, stall = 1'b0, out_ready_i;
  logic irq_o, out_valid_o, out_rec_end_o, blk_done_o, rd_req_o;
  logic [7:0] ch_ready_i, ch_last_i, ch_pop_o;
  logic [255:0] ch_data_i;
  logic [223:0] ch_len_i;
  logic [1:0] avail[8] = '{default: 2'h0}, idx[8] = '{default: 2'h0};
  int bad_count = 0, compares = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  bafrm_framer bafrm_framer_inst (.clk_sys_i, .reset_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .geo_addr_i,
    .geo_auto_i, .fault_status_i, .io_pattern_i, .ch_ready_i, .ch_data_i,
    .ch_valid_i(ch_ready_i), .ch_last_i, .ch_len_i, .ch_pop_o, .blk_start_i,
    .out_ready_i, .out_data_o, .out_valid_o, .out_rec_end_o, .blk_done_o,
    .rd_req_o);
  bafrm_host bafrm_host_inst (.clk_sys_i, .stall_i(stall),
    .data_i(out_data_o), .valid_i(out_valid_o), .ready_o(out_ready_i));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] ln(input int k);
    return 2'(k % 3 + 1);
  endfunction
  always @* for (int k = 0; k < 8; k++) begin
    ch_ready_i[k] = avail[k] != 2'h0;
    ch_last_i[k] = idx[k] == ln(k) - 2'h1;
    ch_data_i[32*k +: 32] = {16'hD0D0, 8'(k), 6'h00, idx[k]};
    ch_len_i[28*k +: 28] = 28'(ln(k));
  end
  // Source advances only after its word was shown with the pop
  always @(posedge clk_sys_i)
    for (int k = 0; k < 8; k++)
      if (ch_pop_o[k] && ch_last_i[k]) begin
        idx[k] <= 2'h0;
        avail[k] <= avail[k] - 2'h1;
      end else if (ch_pop_o[k]) idx[k] <= idx[k] + 2'h1;
  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    cmp("reg", reg_rdata_o, e);
    @(posedge clk_sys_i);
  endtask
  task automatic arm(input logic [7:0] m, input logic [1:0] n);
    for (int k = 0; k < 8; k++) if (m[k]) avail[k] <= n;
    repeat (2) @(posedge clk_sys_i);
    blk_start_i <= 1'b1;
    @(posedge clk_sys_i);
    blk_start_i <= 1'b0;
  endtask
  task automatic chk_rec(input logic [7:0] m, input logic [4:0] id,
                         input logic fl, fresh);
    logic [27:0] len;
    logic [31:0] w[$];
    int p, t;
    len = 28'h4;
    for (int k = 0; k < 8; k++) if (m[k]) len += 28'(ln(k));
    for (t = 0; t < 500 && bafrm_host_inst.words.size() < len; t++)
      @(posedge clk_sys_i);
    if (t == 500) begin
      bad_count++;
      results();
    end
    w = bafrm_host_inst.words;
    cmp("word0", w[0], {4'hA, len});
    cmp("word1", w[1], {8'h00, id, fl, io_pattern_i[9:0], m});
    if (!fresh) cmp("count", w[2], prev_cnt + 32'h1);
    if (!fresh) cmp("time", {31'h0, w[3] > prev_time}, 32'h1);
    prev_cnt = w[2];
    prev_time = w[3];
    p = 4;
    for (int k = 0; k < 8; k++)
      for (int j = 0; m[k] && j < ln(k); j++) begin
        cmp("chan", w[p], {16'hD0D0, 8'(k), 6'h00, 2'(j)});
        p++;
      end
    repeat (len) void'(bafrm_host_inst.words.pop_front());
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic sc_basic;
    avail[0] <= 2'h2;
    arm(8'hA4, 2'h1);
    cmp("req", {31'h0, rd_req_o}, 32'h1);
    chk_rec(8'hA5, 5'h0B, 1'b0, 1'b1);
    arm(8'h00, 2'h0);
    chk_rec(8'h01, 5'h0B, 1'b0, 1'b0);
  endtask
  task automatic sc_limit;
    wr(`BAFRM_ADDR_MAXREC, 32'h2);
    geo_auto_i <= 1'b0;
    stall <= 1'b1;
    arm(8'h02, 2'h3);
    chk_rec(8'h02, 5'h00, 1'b0, 1'b0);
    chk_rec(8'h02, 5'h00, 1'b0, 1'b0);
    repeat (30) @(posedge clk_sys_i);
    cmp("cap", bafrm_host_inst.words.size(), 32'h0);
    stall <= 1'b0;
    arm(8'h00, 2'h0);
    chk_rec(8'h02, 5'h00, 1'b0, 1'b0);
  endtask
  task automatic sc_regs;
    fault_status_i <= 32'h4;
    wr(`BAFRM_ADDR_BID, 32'h13);
    rd_chk(`BAFRM_ADDR_FAIL, 32'h4);
    rd_chk(16'h0100, 32'h0);
    arm(8'h80, 2'h1);
    chk_rec(8'h80, 5'h13, 1'b1, 1'b0);
    repeat (3) @(posedge clk_sys_i);
    rd_chk(`BAFRM_ADDR_IRQST, 32'h7);
    wr(`BAFRM_ADDR_IRQMSK, 32'h2);
    repeat (2) @(posedge clk_sys_i);
    cmp("irq_on", {31'h0, irq_o}, 32'h1);
    wr(`BAFRM_ADDR_IRQST, 32'h2);
    repeat (2) @(posedge clk_sys_i);
    cmp("irq_off", {31'h0, irq_o}, 32'h0);
    rd_chk(`BAFRM_ADDR_IRQST, 32'h5);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    sc_basic();
    sc_limit();
    sc_regs();
    results();
  end
endmodule // tb_top
bind bafrm_framer bafrm_chk bafrm_chk_inst (.clk_sys_i, .reset_n_i,
  .reg_rd_i, .reg_rdata_o, .ch_ready_i, .ch_pop_o, .out_ready_i,
  .out_data_o, .out_valid_o, .out_rec_end_o, .blk_done_o, .rd_req_o);
`default_nettype wire
